// *** design/pzs_pkg.sv ***
// Purpose: Shared constants and types for the PID parameter and zone select block.
// Assumes: Percent values in tenths, factor in hundredths, times in seconds, digits signed.
// Notes: Zero in a time field or the proportional band encodes OFF.
package pzs_pkg;
  localparam int NSETS = 10;
  localparam int SETW = 4;
  // Parameter ranges and power-up defaults (tenths of a percent, seconds, digits).
  localparam logic [13:0] PB_MIN = 14'h0001;
  localparam logic [13:0] PB_MAX = 14'h270F;
  localparam logic [13:0] PB_DEF = 14'h001E;
  localparam logic [13:0] PB_OFF = 14'h0000;
  localparam logic [12:0] TI_MAX = 13'h1770;
  localparam logic [12:0] TI_DEF = 13'h0078;
  localparam logic [12:0] TI_OFF = 13'h0000;
  localparam logic [11:0] TD_MAX = 12'hE10;
  localparam logic [11:0] TD_DEF = 12'h01E;
  localparam logic [11:0] TD_OFF = 12'h000;
  localparam logic signed [10:0] MB_MIN = -11'sh1F4;
  localparam logic signed [10:0] MB_MAX = 11'sh1F4;
  localparam logic signed [10:0] MB_DEF = 11'sh000;
  localparam logic [13:0] HY_MIN = 14'h0001;
  localparam logic [13:0] HY_MAX = 14'h270F;
  localparam logic [13:0] HY_DEF = 14'h0014;
  localparam logic [6:0] SF_MAX = 7'h64;
  localparam logic [6:0] SF_DEF = 7'h28;
  localparam logic [9:0] OL_MAX = 10'h3E7;
  localparam logic [9:0] OL_DEF = 10'h000;
  localparam logic [9:0] OH_MIN = 10'h001;
  localparam logic [9:0] OH_MAX = 10'h3E8;
  localparam logic [9:0] OH_DEF = 10'h3E8;
  localparam logic [13:0] ZB_MAX = 14'h2710;
  localparam logic [13:0] ZB_DEF = 14'h0014;
  localparam logic signed [15:0] ZT_DEF = 16'sh0000;
  localparam logic [SETW-1:0] SET_ONE = 4'h0;

  typedef enum logic [1:0] {
    PZS_ZONE_OFF = 2'b00,
    PZS_ZONE_SP  = 2'b01,
    PZS_ZONE_MV  = 2'b10
  } pzs_zone_mode_t;

  typedef enum logic [1:0] {
    PZS_STAGE_BUF = 2'b00,
    PZS_STAGE_FF  = 2'b01,
    PZS_STAGE_INV = 2'b10
  } pzs_stage_t;

  typedef enum logic [1:0] {
    PZS_GATE_OR  = 2'b00,
    PZS_GATE_AND = 2'b01,
    PZS_GATE_XOR = 2'b10
  } pzs_gate_t;

  // One PID parameter set.
  typedef struct packed {
    logic [13:0] prop_band;
    logic [12:0] integral_time;
    logic [11:0] derivative_time;
    logic signed [10:0] manual_bias;
    logic [13:0] onoff_hysteresis;
    logic [6:0] overshoot_factor;
    logic [9:0] output_low_limit;
    logic [9:0] output_high_limit;
    logic signed [15:0] zone_threshold;
  } pzs_set_t;

  // One event output logic configuration.
  typedef struct packed {
    logic enable;
    pzs_stage_t stage1;
    pzs_stage_t stage2;
    pzs_gate_t gate;
  } pzs_logic_cfg_t;

  localparam pzs_set_t SET_DEF = '{PB_DEF, TI_DEF, TD_DEF, MB_DEF, HY_DEF, SF_DEF,
                                   OL_DEF, OH_DEF, ZT_DEF};
endpackage : pzs_pkg

// *** design/pzs_zone_sel.sv ***
// Purpose: Chooses the active PID set from the zone reference with hysteresis.
// Assumes: Thresholds sorted by set index form zone upper bounds.
// Notes: Hold when the reference is inside the band of any boundary.
`timescale 1ns/10ps
module pzs_zone_sel
  import pzs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_zone_on,
  input wire logic [SETW-1:0] i_fixed_set,
  input wire logic signed [15:0] i_ref,
  input wire logic [13:0] i_band,
  input wire logic [NSETS*16-1:0] i_thresholds,
  output logic [SETW-1:0] o_set
);
  logic [SETW-1:0] cand;
  logic in_band;
  logic signed [17:0] lo_edge;
  logic signed [17:0] hi_edge;
  logic signed [15:0] th;

  // Candidate is the lowest set whose threshold is at or above the reference.
  always_comb begin
    cand = SETW'(NSETS - 1);
    in_band = 1'b0;
    lo_edge = '0;
    hi_edge = '0;
    th = '0;
    for (int k = NSETS - 1; k >= 0; k--) begin
      th = i_thresholds[k*16 +: 16];
      lo_edge = 18'(th) - 18'($signed({4'h0, i_band}));
      hi_edge = 18'(th) + 18'($signed({4'h0, i_band}));
      if (18'(i_ref) <= 18'(th)) begin
        cand = SETW'(k); // R17
      end
      if ((18'(i_ref) > lo_edge) && (18'(i_ref) < hi_edge)) begin
        in_band = 1'b1; // R16
      end
    end
  end

  // Active set register; the band holds the current choice.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_set <= SET_ONE;
    end else if (i_ce) begin
      if (!i_zone_on) begin
        o_set <= i_fixed_set;
      end else if (!in_band) begin
        o_set <= cand; // R18
      end
    end
  end
endmodule : pzs_zone_sel

// *** design/pzs_logic_stage.sv ***
// Purpose: Encodes one event output logic function for the status view.
// Assumes: Configuration comes from the operator.
// Notes: Code is zero when no logic function is assigned.
`timescale 1ns/10ps
module pzs_logic_stage
  import pzs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire pzs_logic_cfg_t i_cfg,
  output logic [6:0] o_code
);
  // Registered code: valid bit, stage one, stage two, gate.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_code <= 7'h00;
    end else if (i_ce) begin
      if (i_cfg.enable) begin
        o_code <= {1'b1, i_cfg.stage1, i_cfg.stage2, i_cfg.gate}; // R20
      end else begin
        o_code <= 7'h00;
      end
    end
  end
endmodule : pzs_logic_stage

// *** design/pzs_core.sv ***
// Purpose: Holds PID parameter sets, selects the active set and shapes the output.
// Assumes: Parameters arrive by a write strobe with a set index; all inputs synchronous.
// Notes: Out-of-range writes are refused and flagged for one cycle.
`timescale 1ns/10ps
// Operation
// R01: Proportional band OFF selects on-off control and blocks auto tuning.
// R02: Proportional band accepts OFF or 0.1 to 999.9 percent, default 3.0.
// R03: Integral time accepts OFF or 1 to 6000 seconds, default 120.
// R04: Derivative time accepts OFF or 1 to 3600 seconds, default 30.
// R05: Tuning with integral OFF stores computed bias into manual bias.
// R06: Tuning with derivative OFF computes proportional and integral only.
// R07: Manual bias accepts -50.0 to 50.0 percent, default 0.0, shifts output.
// R08: Initial operation after power-on or reset-to-run targets the manual bias.
// R09: On-off hysteresis 1 to 9999 digits, default 20, used when band OFF.
// R10: Overshoot factor 0.00 to 1.00, default 0.40, only with integral.
// R11: Factor zero gives plain action; larger factors correct overshoot more.
// R12: During a ramp step the factor switches between full and PD action.
// R13: Output low 0.0 to 99.9, high 0.1 to 100.0, low below high.
// R14: On-off with contact or relay drive output ignores output limits.
// R15: Zone select is OFF, setpoint based or measured value based, default OFF.
// R16: One zone band 0 to 10000 digits, default 20, for all boundaries.
// R17: Each set has a zone threshold, default 0; ties pick the lowest set.
// R18: Inside the zone band the active set stays until the reference leaves.
// R19: Indicators show digital outputs six to nine, hidden when not fitted.
// R20: Logic status encodes each stage and the combining gate.
// R21: With the limiter in effect, clamp the output to the set limits.
module pzs_core
  import pzs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [SETW-1:0] i_wr_set,
  input wire pzs_set_t i_wr_data,
  input wire logic i_zone_wr,
  input wire pzs_zone_mode_t i_zone_mode,
  input wire logic [13:0] i_zone_band,
  input wire logic [SETW-1:0] i_fixed_set,
  input wire logic signed [15:0] i_setpoint,
  input wire logic signed [15:0] i_measured_value,
  input wire logic signed [15:0] i_deviation,
  input wire logic i_run,
  input wire logic i_ramp_step,
  input wire logic i_relay_drive,
  input wire logic i_tune_req,
  input wire logic i_tune_done,
  input wire logic signed [10:0] i_tune_bias,
  input wire logic signed [11:0] i_pid_result,
  input wire logic i_pid_settled,
  input wire logic [3:0] i_do_state,
  input wire logic [3:0] i_do_fitted,
  input wire pzs_logic_cfg_t [5:0] i_logic_cfg,
  output logic [SETW-1:0] o_active_set,
  output pzs_set_t o_active_params,
  output logic o_onoff_mode,
  output logic o_onoff_out,
  output logic o_tune_busy,
  output logic o_tune_refused,
  output logic o_tune_derivative_on,
  output logic o_integral_on,
  output logic o_pd_action,
  output logic [6:0] o_factor_eff,
  output logic [9:0] o_out_value,
  output logic o_wr_error,
  output logic [3:0] o_do_lamp,
  output logic [3:0] o_do_shown,
  output logic [41:0] o_logic_status
);
  pzs_set_t sets_reg [NSETS];
  pzs_zone_mode_t zone_mode_reg;
  logic [13:0] zone_band_reg;
  logic [NSETS*16-1:0] thr_flat;
  logic signed [15:0] zone_ref;
  logic [SETW-1:0] sel_set;
  pzs_set_t act;
  logic wr_ok;
  logic zone_ok;
  logic initial_reg;
  logic run_d_reg;
  logic signed [12:0] mv_next;
  logic [9:0] out_next;
  logic onoff;

  // ------------------------------
  // Parameter storage
  // ------------------------------
  // Write range check over every field of the set except the zone threshold.
  always_comb begin
    wr_ok = 1'b1;
    if ((i_wr_data.prop_band != PB_OFF) && (i_wr_data.prop_band > PB_MAX)) begin
      wr_ok = 1'b0; // R02
    end
    if (i_wr_data.integral_time > TI_MAX) begin
      wr_ok = 1'b0; // R03
    end
    if (i_wr_data.derivative_time > TD_MAX) begin
      wr_ok = 1'b0; // R04
    end
    if ((i_wr_data.manual_bias < MB_MIN) || (i_wr_data.manual_bias > MB_MAX)) begin
      wr_ok = 1'b0; // R07
    end
    if ((i_wr_data.onoff_hysteresis < HY_MIN) || (i_wr_data.onoff_hysteresis > HY_MAX)) begin
      wr_ok = 1'b0; // R09
    end
    if (i_wr_data.overshoot_factor > SF_MAX) begin
      wr_ok = 1'b0; // R10
    end
    if ((i_wr_data.output_low_limit > OL_MAX) || (i_wr_data.output_high_limit < OH_MIN) ||
        (i_wr_data.output_high_limit > OH_MAX) ||
        (i_wr_data.output_low_limit >= i_wr_data.output_high_limit)) begin
      wr_ok = 1'b0; // R13
    end
    if (i_wr_set >= SETW'(NSETS)) begin
      wr_ok = 1'b0;
    end
    zone_ok = (i_zone_band <= ZB_MAX) && (i_zone_mode != pzs_zone_mode_t'(2'b11));
  end

  // Parameter set storage; tuning may overwrite the manual bias of the active set.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NSETS; k++) begin
        sets_reg[k] <= SET_DEF;
      end
    end else if (i_ce) begin
      if (i_wr && wr_ok) begin
        sets_reg[i_wr_set] <= i_wr_data;
      end
      if (o_tune_busy && i_tune_done && (act.integral_time == TI_OFF)) begin
        sets_reg[sel_set].manual_bias <= i_tune_bias; // R05
      end
    end
  end

  // Zone selection settings.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      zone_mode_reg <= PZS_ZONE_OFF; // R15
      zone_band_reg <= ZB_DEF; // R16
    end else if (i_ce) begin
      if (i_zone_wr && zone_ok) begin
        zone_mode_reg <= i_zone_mode;
        zone_band_reg <= i_zone_band;
      end
    end
  end

  // Write refusal flag, one cycle per refused write.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_error <= 1'b0;
    end else if (i_ce) begin
      o_wr_error <= (i_wr && !wr_ok) || (i_zone_wr && !zone_ok);
    end
  end

  // ------------------------------
  // Zone selection
  // ------------------------------
  // Threshold vector and zone reference.
  always_comb begin
    for (int k = 0; k < NSETS; k++) begin
      thr_flat[k*16 +: 16] = sets_reg[k].zone_threshold;
    end
    zone_ref = (zone_mode_reg == PZS_ZONE_MV) ? i_measured_value : i_setpoint; // R15
  end

  pzs_zone_sel u_zone_sel (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_zone_on(zone_mode_reg != PZS_ZONE_OFF),
    .i_fixed_set((i_fixed_set < SETW'(NSETS)) ? i_fixed_set : SET_ONE),
    .i_ref(zone_ref),
    .i_band(zone_band_reg),
    .i_thresholds(thr_flat),
    .o_set(sel_set)
  );

  assign act = sets_reg[sel_set];
  assign onoff = (act.prop_band == PB_OFF);

  // ------------------------------
  // Control
  // ------------------------------
  // Tuning control: refused when on-off control is active.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tune_busy <= 1'b0;
      o_tune_refused <= 1'b0;
      o_tune_derivative_on <= 1'b0;
    end else if (i_ce) begin
      o_tune_refused <= i_tune_req && onoff; // R01
      if (i_tune_req && !onoff && !o_tune_busy) begin
        o_tune_busy <= 1'b1;
        o_tune_derivative_on <= (act.derivative_time != TD_OFF); // R06
      end else if (i_tune_done || onoff) begin
        o_tune_busy <= 1'b0;
      end
    end
  end

  // Initial operation tracking after power-on or reset-to-run.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      initial_reg <= 1'b1;
      run_d_reg <= 1'b0;
    end else if (i_ce) begin
      run_d_reg <= i_run;
      if (i_run && !run_d_reg) begin
        initial_reg <= 1'b1; // R08
      end else if (i_pid_settled) begin
        initial_reg <= 1'b0;
      end
    end
  end

  // Manipulated value: bias shift, initial target, clamp unless on-off relay drive.
  always_comb begin
    if (initial_reg) begin
      mv_next = 13'(act.manual_bias) + 13'sh01F4; // R08
    end else begin
      mv_next = 13'(i_pid_result) + 13'(act.manual_bias); // R07
    end
    if (onoff) begin
      out_next = o_onoff_out ? OH_MAX : 10'h000;
    end else if (mv_next < 13'sh0000) begin
      out_next = 10'h000;
    end else if (mv_next > 13'(OH_MAX)) begin
      out_next = OH_MAX;
    end else begin
      out_next = mv_next[9:0];
    end
    if (!(onoff && i_relay_drive)) begin // R14
      if (out_next < act.output_low_limit) begin
        out_next = act.output_low_limit; // R21
      end else if (out_next > act.output_high_limit) begin
        out_next = act.output_high_limit; // R21
      end
    end
  end

  // On-off action with hysteresis on the deviation (setpoint minus measured).
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_onoff_out <= 1'b0;
    end else if (i_ce) begin
      if (!onoff || !i_run) begin
        o_onoff_out <= 1'b0;
      end else if (17'(i_deviation) >= 17'($signed({3'h0, act.onoff_hysteresis}))) begin
        o_onoff_out <= 1'b1; // R09
      end else if (i_deviation <= 16'sh0000) begin
        o_onoff_out <= 1'b0; // R09
      end
    end
  end

  // Control outputs and overshoot factor gating.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_active_set <= SET_ONE;
      o_active_params <= SET_DEF;
      o_onoff_mode <= 1'b0;
      o_integral_on <= 1'b1;
      o_pd_action <= 1'b0;
      o_factor_eff <= 7'h00;
      o_out_value <= 10'h000;
    end else if (i_ce) begin
      o_active_set <= sel_set;
      o_active_params <= act;
      o_onoff_mode <= onoff; // R01
      o_integral_on <= (act.integral_time != TI_OFF);
      o_factor_eff <= (act.integral_time != TI_OFF) ? act.overshoot_factor : 7'h00; // R10 R11
      o_pd_action <= i_ramp_step && (act.integral_time != TI_OFF) &&
                     (act.overshoot_factor != 7'h00); // R12
      o_out_value <= out_next;
    end
  end

  // ------------------------------
  // Status indicators
  // ------------------------------
  // Digital output indicators.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_do_lamp <= 4'h0;
      o_do_shown <= 4'h0;
    end else if (i_ce) begin
      o_do_lamp <= i_do_state & i_do_fitted; // R19
      o_do_shown <= i_do_fitted; // R19
    end
  end

  // Logic status encoders, one per event output.
  for (genvar g = 0; g < 6; g++) begin : g_logic
    pzs_logic_stage u_stage (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_cfg(i_logic_cfg[g]),
      .o_code(o_logic_status[g*7 +: 7])
    );
  end
endmodule : pzs_core

// *** test/pzs_core_properties.sv ***
// Purpose: Port checker for pzs_core.
// Assumes: One clock domain, reset active high.
// Notes: Bound to every pzs_core instance.
`timescale 1ns/10ps
module pzs_core_properties
  import pzs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire pzs_set_t i_wr_data,
  input wire logic [3:0] i_do_state,
  input wire logic [3:0] i_do_fitted,
  input wire logic o_integral_on,
  input wire logic o_pd_action,
  input wire logic [6:0] o_factor_eff,
  input wire logic o_wr_error,
  input wire logic [3:0] o_do_lamp,
  input wire logic [3:0] o_do_shown
);
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic wt;
  pzs_set_t d;
  // A write is taken on an enabled strobe edge.
  assign wt = i_ce && i_wr;
  assign d = i_wr_data;
  AST_PB_RANGE: assert property (wt && d.prop_band > PB_MAX |=> ##[0:1] o_wr_error)
    else $error("band write not refused");
  AST_TI_RANGE: assert property (wt && d.integral_time > TI_MAX |=> ##[0:1] o_wr_error)
    else $error("integral write not refused");
  AST_TD_RANGE: assert property (wt && d.derivative_time > TD_MAX |=> ##[0:1] o_wr_error)
    else $error("derivative write not refused");
  AST_MB_RANGE: assert property (wt && (d.manual_bias > MB_MAX || d.manual_bias < MB_MIN)
    |=> ##[0:1] o_wr_error) else $error("bias write not refused");
  AST_HY_ZERO: assert property (wt && d.onoff_hysteresis == 14'h0000 |=> ##[0:1] o_wr_error)
    else $error("hysteresis write not refused");
  AST_SF_RANGE: assert property (wt && d.overshoot_factor > SF_MAX |=> ##[0:1] o_wr_error)
    else $error("factor write not refused");
  AST_LIM_ORDER: assert property (wt && d.output_low_limit >= d.output_high_limit
    |=> ##[0:1] o_wr_error) else $error("limit order not refused");
  AST_SF_NEEDS_I: assert property (!o_integral_on |-> o_factor_eff == 7'h00)
    else $error("factor active without integral");
  AST_PD_COND: assert property (o_pd_action |-> o_integral_on && o_factor_eff != 7'h00)
    else $error("pd action without cause");
  AST_LAMP: assert property (i_ce |=> o_do_lamp == ($past(i_do_state) & $past(i_do_fitted)))
    else $error("lamp mismatch");
  AST_SHOWN: assert property (i_ce |=> o_do_shown == $past(i_do_fitted))
    else $error("shown mismatch");
endmodule : pzs_core_properties

bind pzs_core pzs_core_properties i_props (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_ce(i_ce), .i_wr(i_wr), .i_wr_data(i_wr_data), .i_do_state(i_do_state),
  .i_do_fitted(i_do_fitted), .o_integral_on(o_integral_on), .o_pd_action(o_pd_action),
  .o_factor_eff(o_factor_eff), .o_wr_error(o_wr_error), .o_do_lamp(o_do_lamp),
  .o_do_shown(o_do_shown));

// *** test/pzs_core_tb.sv ***
// Purpose: Self-checking bench for pzs_core.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Random values come from a 16-bit LFSR seeded with 9.
`timescale 1ns/10ps
module pzs_core_tb;
  import pzs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, zw = 1'b0, run = 1'b0, ramp = 1'b0;
  logic relay = 1'b0, treq = 1'b0, tdone = 1'b0, pst = 1'b0, onm, ono, tbusy, tref, tder;
  logic ion, pd, werr;
  logic [3:0] ws = 4'h0, fs = 4'h0, dos = 4'h0, dof = 4'h0, aset, lamp, shown;
  logic [13:0] zb = ZB_DEF;
  logic signed [15:0] sp = 16'sh0000, mv = 16'sh0000, dv = 16'sh0000;
  logic signed [10:0] tbias = 11'sh000;
  logic signed [11:0] pr = 12'sh000;
  logic [6:0] fe;
  logic [9:0] ov;
  logic [41:0] lst;
  logic [15:0] lf = 16'h0009;
  pzs_zone_mode_t zm = PZS_ZONE_OFF;
  pzs_logic_cfg_t [5:0] lc = '0;
  pzs_set_t wd = SET_DEF, ap, s, b;
  int errors = 0, checked = 0, r, e;
  int zr[8] = '{150, 115, 50, 95, 110, 130, 250, 2000};
  int ze[8] = '{1, 1, 0, 0, 0, 1, 2, 9};
  int dd[6] = '{10, 50, 20, 0, 30, 60};
  int de[6] = '{0, 1, 1, 0, 0, 1};

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  pzs_core i_pzs_core (.i_sys_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_wr(wr), .i_wr_set(ws),
    .i_wr_data(wd), .i_zone_wr(zw), .i_zone_mode(zm), .i_zone_band(zb), .i_fixed_set(fs),
    .i_setpoint(sp), .i_measured_value(mv), .i_deviation(dv), .i_run(run),
    .i_ramp_step(ramp), .i_relay_drive(relay), .i_tune_req(treq), .i_tune_done(tdone),
    .i_tune_bias(tbias), .i_pid_result(pr), .i_pid_settled(pst), .i_do_state(dos),
    .i_do_fitted(dof), .i_logic_cfg(lc), .o_active_set(aset), .o_active_params(ap),
    .o_onoff_mode(onm), .o_onoff_out(ono), .o_tune_busy(tbusy), .o_tune_refused(tref),
    .o_tune_derivative_on(tder), .o_integral_on(ion), .o_pd_action(pd), .o_factor_eff(fe),
    .o_out_value(ov), .o_wr_error(werr), .o_do_lamp(lamp), .o_do_shown(shown),
    .o_logic_status(lst));

  // ------------------------------
  // Helpers
  // ------------------------------
  function logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  // Draws a parameter set that lies inside every range.
  function pzs_set_t gs();
    pzs_set_t g;
    g.prop_band = 14'(1 + rnd() % 9999);
    g.integral_time = 13'(rnd() % 6001);
    g.derivative_time = 12'(rnd() % 3601);
    g.manual_bias = 11'(int'(rnd() % 1001) - 500);
    g.onoff_hysteresis = 14'(1 + rnd() % 9999);
    g.overshoot_factor = 7'(rnd() % 101);
    g.output_low_limit = 10'(rnd() % 500);
    g.output_high_limit = 10'(500 + rnd() % 501);
    g.zone_threshold = 16'(rnd());
    return g;
  endfunction : gs

  // Status code expected for the current logic configuration.
  function logic [41:0] els();
    els = '0;
    for (int k = 0; k < 6; k++) begin
      if (lc[k].enable) els[7*k +: 7] = {1'b1, lc[k].stage1, lc[k].stage2, lc[k].gate};
    end
  endfunction : els

  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick

  task chk(input string nm, input logic [127:0] x, input logic [127:0] g);
    checked++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, x, g);
    end
  endtask : chk

  task wset(input logic [3:0] n, input pzs_set_t v);
    ws = n;
    wd = v;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : wset

  // Expects exactly one pulse within three cycles.
  task pulse(input string nm, input bit w);
    int n;
    n = 0;
    repeat (3) begin
      if ((w ? tref : werr) === 1'b1) n++;
      tick(1);
    end
    chk(nm, 1, n);
  endtask : pulse

  task stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ------------------------------
  // Sequence
  // ------------------------------
  // Watchdog sized well beyond the few hundred cycles the sequence needs.
  initial begin
    #400000;
    errors++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    tick(3);
    chk("defaults", SET_DEF, ap);
    chk("reset set", 0, aset);
    fs = 4'h3;
    for (int i = 0; i < 6; i++) begin
      s = gs();
      wset(3, s);
      tick(3);
      chk("params", s, ap);
    end
    wset(5, gs());
    tick(3);
    chk("other set", s, ap);
    for (int k = 0; k < 8; k++) begin
      b = s;
      case (k)
        0: b.prop_band = 14'h2710;
        1: b.integral_time = 13'h1771;
        2: b.derivative_time = 12'hE11;
        3: b.manual_bias = 11'sh1F5;
        4: b.manual_bias = -11'sh1F5;
        5: b.onoff_hysteresis = 14'h0000;
        6: b.overshoot_factor = 7'h65;
        default: b.output_high_limit = b.output_low_limit;
      endcase
      wset(3, b);
      pulse("write error", 1'b0);
      chk("kept", s, ap);
    end
    ce = 1'b0;
    wset(3, gs());
    tick(2);
    ce = 1'b1;
    tick(3);
    chk("frozen", s, ap);
    for (int k = 0; k < 10; k++) begin
      b = SET_DEF;
      b.zone_threshold = 16'((k == 3 ? 3 : k + 1) * 100);
      wset(4'(k), b);
      tick(1);
    end
    tick(3);
    chk("fixed set", 3, aset);
    for (int m = 1; m < 3; m++) begin
      zm = pzs_zone_mode_t'(m);
      zw = 1'b1;
      tick(1);
      zw = 1'b0;
      for (int j = 0; j < 8; j++) begin
        sp = 16'(m == 1 ? zr[j] : 2000);
        mv = 16'(m == 1 ? 2000 : zr[j]);
        tick(4);
        chk("zone set", ze[j], aset);
      end
      chk("zone params", 1000, ap.zone_threshold);
    end
    zm = PZS_ZONE_OFF;
    zw = 1'b1;
    fs = 4'h0;
    tick(1);
    zw = 1'b0;
    b = SET_DEF;
    b.prop_band = 14'h0000;
    b.onoff_hysteresis = 14'h0032;
    b.output_low_limit = 10'h0C8;
    b.output_high_limit = 10'h320;
    wset(0, b);
    run = 1'b1;
    relay = 1'b1;
    tick(3);
    chk("onoff mode", 1, onm);
    treq = 1'b1;
    tick(1);
    treq = 1'b0;
    pulse("tune refused", 1'b1);
    for (int j = 0; j < 6; j++) begin
      dv = 16'(dd[j]);
      tick(3);
      chk("onoff out", de[j], ono);
    end
    // Relay drive bypasses the limits; without it the high limit applies.
    chk("relay out", OH_MAX, ov);
    relay = 1'b0;
    tick(2);
    chk("limited out", 10'h320, ov);
    run = 1'b0;
    relay = 1'b0;
    b = SET_DEF;
    b.integral_time = 13'h0000;
    b.manual_bias = 11'sh064;
    b.output_low_limit = 10'h0C8;
    b.output_high_limit = 10'h320;
    wset(0, b);
    tick(1);
    run = 1'b1;
    tick(4);
    chk("initial out", 600, ov);
    chk("integral", 0, ion);
    chk("factor", 0, fe);
    pst = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = int'(rnd() % 2001) - 1000;
      pr = 12'(r);
      e = r + 100;
      if (e < 200) e = 200;
      if (e > 800) e = 800;
      tick(3);
      chk("out", e, ov);
    end
    b.integral_time = 13'h0078;
    wset(0, b);
    ramp = 1'b1;
    tick(3);
    chk("pd", 1, pd);
    chk("factor", 40, fe);
    b.overshoot_factor = 7'h00;
    wset(0, b);
    tick(3);
    chk("pd off", 0, pd);
    ramp = 1'b0;
    b = SET_DEF;
    b.integral_time = 13'h0000;
    b.derivative_time = 12'h000;
    for (int t = 0; t < 2; t++) begin
      wset(0, b);
      tick(2);
      treq = 1'b1;
      tick(1);
      treq = 1'b0;
      tick(2);
      chk("busy", 1, tbusy);
      chk("derivative", t, tder);
      tbias = 11'(t * 10 - 77);
      tdone = 1'b1;
      tick(1);
      tdone = 1'b0;
      tick(3);
      chk("idle", 0, tbusy);
      chk("bias", {tbias}, {ap.manual_bias});
      b.derivative_time = 12'h01E;
    end
    for (int i = 0; i < 8; i++) begin
      dos = 4'(rnd());
      dof = 4'(rnd());
      for (int k = 0; k < 6; k++) begin
        lc[k] = '{1'(rnd()), pzs_stage_t'(rnd() % 3), pzs_stage_t'(rnd() % 3),
                  pzs_gate_t'(rnd() % 3)};
      end
      tick(3);
      chk("lamp", dos & dof, lamp);
      chk("shown", dof, shown);
      chk("logic", els(), lst);
    end
    stop_test();
  end
endmodule : pzs_core_tb
